// ==== hw/arbiter_defines.vh ====
// register offsets, field positions, reset values for the memory arbiter block
// assumes an 8-bit special-register port from the cpu core on one clock
`ifndef ARBITER_DEFINES_VH
`define ARBITER_DEFINES_VH
`define ADDR_POINTER_ZERO_LOW 8'h82
`define ADDR_POINTER_ZERO_HIGH 8'h83
`define ADDR_POINTER_ONE_LOW 8'h84
`define ADDR_POINTER_ONE_HIGH 8'h85
`define ADDR_POINTER_SELECT 8'h92
`define ADDR_EXTERNAL_PAGE_SELECT 8'h93
`define ADDR_FLASH_BANK_WINDOW_MAP 8'h9F
`define ADDR_ARBITER_CONTROL 8'hC7
`define CTRL_UNIFIED_BIT 6
`define CTRL_BANK_HI 5
`define CTRL_BANK_LO 4
`define CTRL_CACHE_OFF_BIT 1
`define CTRL_RESERVED_BIT 0
`define RESET_PAGE 8'h00
`define RESET_BANK 2'h1
`define RESET_POINTER 8'h00
`define RESET_RESERVED 1'h1
`define UPPER_WINDOW_BASE 16'h8000
`define FLASH_ADDR_W 17
`endif

// ==== hw/code_window_map.v ====
// code-space address mapper: turns a 16-bit code address into a physical target
// assumes flash banks of 32 KB, ram placed above flash when unified mapping is on
module code_window_map #(
  parameter RAM_CODE_BASE = 16'hE000
) (
  input wire [15:0] code_addr,
  input wire [1:0] bank,
  input wire bank_enable,
  input wire unified_code_mapping,
  output reg [16:0] flash_addr,
  output reg ram_hit
);
  always @* begin
    ram_hit = 1'b0;
    flash_addr = {1'b0, code_addr};
    if (unified_code_mapping && code_addr >= RAM_CODE_BASE) begin
      ram_hit = 1'b1;
    end else if (code_addr[15] && bank_enable) begin
      flash_addr = {bank, code_addr[14:0]};
    end
  end
endmodule

// ==== hw/memory_arbiter.v ====
// memory arbiter, external page, bank window, cache control and data pointers
// assumes cpu and dma requesters on sys_clk; sfr port is the cpu special-register bus
//
// Contract
// - indirect external moves take high byte from page register, low from index.
// - page register is 8-bit read/write, reset zero.
// - arbiter serves cpu and dma requests to every memory. Code routes dma requests only to xdata_addr, never to flash.
// - unified mapping bit 6 maps all memories into code space; reset zero. Code maps only ram, at RAM_CODE_BASE and up.
// - bank bits in control and bank map register share one storage.
// - bank selects which 32 KB bank sits at code 0x8000-0xFFFF; reset 01.
// - bank codes 00..11 map window to flash 0x00000,0x08000,0x10000,0x18000.
// - bank switching works only on the 128 KB flash variant.
// - cache-off bit 1 invalidates cache, fetches go straight to flash.
// - two data pointers; select bit 0 chooses the active one.
// - each pointer is 16 bits from separately accessible high and low bytes.
// - select 0 means pointer zero, 1 pointer one; resets to 0.
`include "arbiter_defines.vh"
module memory_arbiter #(
  parameter FLASH_KB = 128,
  parameter RAM_CODE_BASE = 16'hE000
) (
  input wire sys_clk,
  input wire sys_rst,
  input wire sfr_wr,
  input wire sfr_rd,
  input wire [7:0] sfr_addr,
  input wire [7:0] sfr_wdata,
  output reg [7:0] sfr_rdata,
  input wire cpu_req,
  input wire cpu_fetch,
  input wire cpu_indirect,
  input wire [7:0] indirect_index_register,
  input wire [15:0] cpu_addr,
  output reg cpu_grant,
  input wire dma_req,
  input wire [15:0] dma_addr,
  output reg dma_grant,
  output reg [15:0] xdata_addr,
  output reg [16:0] flash_addr,
  output reg code_ram_hit,
  output reg [15:0] active_pointer,
  output reg cache_invalidate,
  output reg cache_bypass
);
  localparam ST_CPU = 2'b01;
  localparam ST_DMA = 2'b10;

  reg [7:0] external_page_select_r;
  reg [1:0] bank_r;
  reg unified_code_mapping_r;
  reg instruction_cache_off_r;
  reg reserved_r;
  reg pointer_select_r;
  reg [7:0] pointer_low_r [0:1];
  reg [7:0] pointer_high_r [0:1];
  reg [1:0] last_r;
  reg [1:0] grant_nxt;
  reg [7:0] rdata_nxt;
  wire bank_enable = (FLASH_KB == 128);
  wire [15:0] cpu_eff_addr;
  wire [16:0] map_flash;
  wire map_ram;

  function sel;
    input [7:0] addr;
    input [7:0] target;
    begin
      sel = (addr == target);
    end
  endfunction

  // page register forms the high byte of @index external moves
  assign cpu_eff_addr = cpu_indirect ?
    {external_page_select_r, indirect_index_register} : cpu_addr;

  code_window_map #(.RAM_CODE_BASE(RAM_CODE_BASE)) u_map (
    .code_addr(cpu_addr),
    .bank(bank_r),
    .bank_enable(bank_enable),
    .unified_code_mapping(unified_code_mapping_r),
    .flash_addr(map_flash),
    .ram_hit(map_ram)
  );

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      external_page_select_r <= `RESET_PAGE;
      bank_r <= `RESET_BANK;
      unified_code_mapping_r <= 1'b0;
      instruction_cache_off_r <= 1'b0;
      reserved_r <= `RESET_RESERVED;
      pointer_select_r <= 1'b0;
    end else if (sfr_wr) begin
      if (sel(sfr_addr, `ADDR_EXTERNAL_PAGE_SELECT)) begin
        external_page_select_r <= sfr_wdata;
      end else if (sel(sfr_addr, `ADDR_FLASH_BANK_WINDOW_MAP)) begin
        bank_r <= sfr_wdata[1:0];
      end else if (sel(sfr_addr, `ADDR_ARBITER_CONTROL)) begin
        bank_r <= sfr_wdata[`CTRL_BANK_HI:`CTRL_BANK_LO];
        unified_code_mapping_r <= sfr_wdata[`CTRL_UNIFIED_BIT];
        instruction_cache_off_r <= sfr_wdata[`CTRL_CACHE_OFF_BIT];
        // kept as written; software is expected to write one here
        reserved_r <= sfr_wdata[`CTRL_RESERVED_BIT];
      end else if (sel(sfr_addr, `ADDR_POINTER_SELECT)) begin
        pointer_select_r <= sfr_wdata[0];
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_ptr
      // each pointer pair sits two addresses above the previous one
      localparam [7:0] PTR_OFS = (g == 0) ? 8'h00 : 8'h02;
      always @(posedge sys_clk) begin
        if (sys_rst) begin
          pointer_low_r[g] <= `RESET_POINTER;
          pointer_high_r[g] <= `RESET_POINTER;
        end else if (sfr_wr) begin
          if (sel(sfr_addr, `ADDR_POINTER_ZERO_LOW + PTR_OFS)) begin
            pointer_low_r[g] <= sfr_wdata;
          end else if (sel(sfr_addr, `ADDR_POINTER_ZERO_HIGH + PTR_OFS)) begin
            pointer_high_r[g] <= sfr_wdata;
          end
        end
      end
    end
  endgenerate

  always @* begin
    rdata_nxt = 8'h00;
    if (sel(sfr_addr, `ADDR_EXTERNAL_PAGE_SELECT)) begin
      rdata_nxt = external_page_select_r;
    end else if (sel(sfr_addr, `ADDR_FLASH_BANK_WINDOW_MAP)) begin
      rdata_nxt = {6'h00, bank_r};
    end else if (sel(sfr_addr, `ADDR_ARBITER_CONTROL)) begin
      rdata_nxt = {1'b0, unified_code_mapping_r, bank_r, 2'b00,
        instruction_cache_off_r, reserved_r};
    end else if (sel(sfr_addr, `ADDR_POINTER_SELECT)) begin
      rdata_nxt = {7'h00, pointer_select_r};
    end else if (sel(sfr_addr, `ADDR_POINTER_ZERO_LOW)) begin
      rdata_nxt = pointer_low_r[0];
    end else if (sel(sfr_addr, `ADDR_POINTER_ZERO_HIGH)) begin
      rdata_nxt = pointer_high_r[0];
    end else if (sel(sfr_addr, `ADDR_POINTER_ONE_LOW)) begin
      rdata_nxt = pointer_low_r[1];
    end else if (sel(sfr_addr, `ADDR_POINTER_ONE_HIGH)) begin
      rdata_nxt = pointer_high_r[1];
    end
  end

  // round robin so a busy cpu never starves dma and vice versa
  always @* begin
    grant_nxt = 2'b00;
    case (last_r)
      ST_CPU: begin
        if (dma_req) grant_nxt = ST_DMA;
        else if (cpu_req) grant_nxt = ST_CPU;
      end
      default: begin
        if (cpu_req) grant_nxt = ST_CPU;
        else if (dma_req) grant_nxt = ST_DMA;
      end
    endcase
  end

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      last_r <= ST_DMA;
      cpu_grant <= 1'b0;
      dma_grant <= 1'b0;
      xdata_addr <= 16'h0000;
      flash_addr <= 17'h00000;
      code_ram_hit <= 1'b0;
      active_pointer <= 16'h0000;
      cache_invalidate <= 1'b0;
      cache_bypass <= 1'b0;
      sfr_rdata <= 8'h00;
    end else begin
      if (grant_nxt != 2'b00) last_r <= grant_nxt;
      cpu_grant <= grant_nxt[0];
      dma_grant <= grant_nxt[1];
      xdata_addr <= grant_nxt[1] ? dma_addr : cpu_eff_addr;
      flash_addr <= map_flash;
      code_ram_hit <= map_ram && cpu_fetch;
      active_pointer <= pointer_select_r ? {pointer_high_r[1], pointer_low_r[1]} :
        {pointer_high_r[0], pointer_low_r[0]};
      // one-cycle invalidate when the bypass is switched on
      cache_invalidate <= instruction_cache_off_r && !cache_bypass;
      cache_bypass <= instruction_cache_off_r;
      sfr_rdata <= sfr_rd ? rdata_nxt : 8'h00;
    end
  end
endmodule

// ==== tb/cpu_dma_model.sv ====
// requester model: cpu core and dma controller issuing memory requests
// assumes registered grants; request and qualifiers held until a grant is sampled
module cpu_dma_model (
  input wire sys_clk,
  input wire cpu_grant,
  input wire dma_grant,
  output logic cpu_req = 0,
  output logic dma_req = 0,
  output logic cpu_fetch = 0,
  output logic cpu_indirect = 0,
  output logic [7:0] indirect_index_register = 8'h00,
  output logic [15:0] cpu_addr = 16'h0000,
  output logic [15:0] dma_addr = 16'h0000
);
  timeunit 1ns;
  timeprecision 1ps;
  task automatic go(input d, input [15:0] a, input f, input i, input [7:0] x, output ok);
    ok = 0;
    @(posedge sys_clk);
    if (d) begin
      dma_addr <= a;
      dma_req <= 1;
    end else begin
      cpu_addr <= a;
      cpu_fetch <= f;
      cpu_indirect <= i;
      indirect_index_register <= x;
      cpu_req <= 1;
    end
    for (int n = 0; n < 8 && !ok; n++) begin
      @(posedge sys_clk);
      ok = d ? dma_grant : cpu_grant;
    end
    // released address lines invert so a stale value cannot pass for a held one
    if (d) begin
      dma_req <= 0;
      dma_addr <= ~a;
    end else begin
      cpu_req <= 0;
      cpu_addr <= ~a;
    end
  endtask
endmodule

// ==== tb/memory_arbiter_sva.sv ====
// port checks for memory_arbiter: grants, address forming, code window, cache pulse
// assumes one clock domain with synchronous active-high reset; bound at the foot
module memory_arbiter_sva #(
  parameter RAM_CODE_BASE = 16'hE000
) (
  input wire sys_clk,
  input wire sys_rst,
  input wire cpu_req,
  input wire cpu_fetch,
  input wire cpu_indirect,
  input wire [7:0] indirect_index_register,
  input wire [15:0] cpu_addr,
  input wire cpu_grant,
  input wire dma_req,
  input wire [15:0] dma_addr,
  input wire dma_grant,
  input wire [15:0] xdata_addr,
  input wire [16:0] flash_addr,
  input wire code_ram_hit,
  input wire cache_invalidate,
  input wire cache_bypass
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  sequence s_cpu_only;
    cpu_req && !dma_req;
  endsequence
  sequence s_both;
    cpu_req && dma_req ##1 cpu_req && dma_req;
  endsequence
  a_cpu_served: assert property (s_cpu_only |=> cpu_grant)
    else $error("lone cpu request not granted");
  a_dma_served: assert property (dma_req && !cpu_req |=> dma_grant && xdata_addr == $past(dma_addr))
    else $error("lone dma request not served");
  a_grant_single: assert property (!(cpu_grant && dma_grant))
    else $error("both requesters granted");
  a_both_alternate: assert property (s_both |=> cpu_grant != $past(cpu_grant))
    else $error("arbiter did not alternate");
  a_index_low: assert property (s_cpu_only ##0 cpu_indirect |=> xdata_addr[7:0] == $past(indirect_index_register))
    else $error("indirect low byte wrong");
  a_window_low: assert property (cpu_req && !cpu_addr[15] |=> flash_addr == {1'b0, $past(cpu_addr)})
    else $error("lower code half not flat");
  a_window_high: assert property (cpu_req && cpu_addr[15] |=> (flash_addr & 17'h07FFF) == ({1'b0, $past(cpu_addr)} & 17'h07FFF))
    else $error("bank window offset wrong");
  a_ram_hit: assert property (code_ram_hit |-> $past(cpu_fetch) && $past(cpu_addr) >= RAM_CODE_BASE)
    else $error("ram hit without ram fetch");
  a_inval_pulse: assert property (cache_invalidate |=> !cache_invalidate)
    else $error("cache invalidate longer than a pulse");
  a_inval_on_bypass: assert property ($rose(cache_bypass) |-> cache_invalidate)
    else $error("cache not invalidated when bypass switched on");
endmodule
bind memory_arbiter memory_arbiter_sva #(.RAM_CODE_BASE(RAM_CODE_BASE)) u_sva (.sys_clk, .sys_rst,
  .cpu_req, .cpu_fetch, .cpu_indirect, .indirect_index_register, .cpu_addr, .cpu_grant, .dma_req,
  .dma_addr, .dma_grant, .xdata_addr, .flash_addr, .code_ram_hit, .cache_invalidate,
  .cache_bypass);

// ==== tb/tb_top.sv ====
// self-checking bench: sfr read and write tasks plus the requester model
// assumes memory_arbiter and cpu_dma_model are compiled first
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 0, sys_rst = 1, sfr_wr = 0, sfr_rd = 0, ok, ok2;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, indirect_index_register;
  logic cpu_req, cpu_fetch, cpu_indirect, cpu_grant, dma_req, dma_grant;
  logic code_ram_hit, cache_invalidate, cache_bypass;
  logic [15:0] cpu_addr, dma_addr, xdata_addr, active_pointer;
  logic [16:0] flash_addr;
  logic [7:0] ra [8] = '{8'h93, 8'h9F, 8'hC7, 8'h92, 8'h82, 8'h83, 8'h84, 8'h85};
  int num_errors = 0, comparisons = 0;
  initial forever #4 sys_clk = ~sys_clk;
  memory_arbiter DUT (.sys_clk, .sys_rst, .sfr_wr, .sfr_rd, .sfr_addr, .sfr_wdata, .sfr_rdata,
    .cpu_req, .cpu_fetch, .cpu_indirect, .indirect_index_register, .cpu_addr, .cpu_grant,
    .dma_req, .dma_addr, .dma_grant, .xdata_addr, .flash_addr, .code_ram_hit, .active_pointer,
    .cache_invalidate, .cache_bypass);
  cpu_dma_model m (.sys_clk, .cpu_grant, .dma_grant, .cpu_req, .dma_req, .cpu_fetch,
    .cpu_indirect, .indirect_index_register, .cpu_addr, .dma_addr);
  task chk(input string n, input logic [16:0] e, input logic [16:0] g);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task wrap_up;
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task wr(input [7:0] a, input [7:0] d);
    @(posedge sys_clk);
    sfr_wr <= 1;
    sfr_addr <= a;
    sfr_wdata <= d;
    @(posedge sys_clk);
    sfr_wr <= 0;
  endtask
  task rd(input [7:0] a, input [7:0] e);
    @(posedge sys_clk);
    sfr_rd <= 1;
    sfr_addr <= a;
    @(posedge sys_clk);
    sfr_rd <= 0;
    #1 chk("sfr_rdata", e, sfr_rdata);
  endtask
  task acc(input d, input [15:0] a, input f, input i, input [7:0] x);
    m.go(d, a, f, i, x, ok);
    chk("grant", 1, ok);
    if (ok !== 1'b1) wrap_up;
  endtask
  initial begin
    repeat (4) @(posedge sys_clk);
    sys_rst <= 0;
    foreach (ra[i]) rd(ra[i], i == 1 ? 8'h01 : i == 2 ? 8'h11 : 8'h00);
    $display("reset values done");
    wr(8'h93, 8'hFF);
    rd(8'h93, 8'hFF);
    wr(8'h9F, 8'hFE);
    rd(8'hC7, 8'h21);
    wr(8'hC7, 8'hFD);
    rd(8'hC7, 8'h71);
    rd(8'h9F, 8'h03);
    rd(8'h81, 8'h00);
    wr(8'h92, 8'hFF);
    rd(8'h92, 8'h01);
    $display("register map done");
    for (int b = 0; b < 4; b++) begin
      wr(8'h9F, b[7:0]);
      acc(0, 16'h8123, 1, 0, 8'h00);
      chk("flash_addr", 17'h00123 + b * 17'h08000, flash_addr);
    end
    // unified mapping is already on before the ram fetch
    acc(0, 16'hE010, 1, 0, 8'h00);
    chk("code_ram_hit", 1, code_ram_hit);
    wr(8'hC7, 8'h03);
    acc(0, 16'hE010, 1, 0, 8'h00);
    chk("code_ram_hit", 0, code_ram_hit);
    chk("cache_bypass", 1, cache_bypass);
    wr(8'hC7, 8'h01);
    wr(8'h93, 8'hA5);
    acc(0, 16'h0000, 0, 1, 8'h3C);
    chk("xdata_addr", 16'hA53C, xdata_addr);
    acc(1, 16'h1234, 0, 0, 8'h00);
    chk("xdata_addr", 16'h1234, xdata_addr);
    chk("cache_bypass", 0, cache_bypass);
    fork
      m.go(0, 16'h0100, 0, 0, 8'h00, ok);
      m.go(1, 16'h0200, 0, 0, 8'h00, ok2);
    join
    chk("both grants", 2'b11, {ok, ok2});
    $display("arbiter and mapping done");
    for (int i = 4; i < 8; i++) wr(ra[i], 8'h11 * i);
    wr(8'h92, 8'h00);
    repeat (2) @(posedge sys_clk);
    chk("active_pointer", 16'h5544, active_pointer);
    wr(8'h92, 8'h01);
    repeat (2) @(posedge sys_clk);
    chk("active_pointer", 16'h7766, active_pointer);
    $display("pointer test done");
    wrap_up;
  end
endmodule
